// ===== core/vcds_params.svh
`ifndef VCDS_PARAMS_SVH
`define VCDS_PARAMS_SVH
`define VCDS_CLK_DIV       16
`define VCDS_VCNT_PRESET   10'h014
`define VCDS_VCNT_STD_END  10'h221
`define VCDS_FREE_PERIOD   684
`define VCDS_IMMUNE_CNT    384
`define VCDS_BLANK_CLKS    608
`define VCDS_RAMP_CLKS     192
`define VCDS_EQ_LINES      6
`define VCDS_EQ_MIN        9
`define VCDS_NOISE_MIN     2
`define VCDS_FIELDS_CONF   7
`endif

// ===== core/vcds_pkg.sv
package vcds_pkg;
	typedef enum logic [1:0] {
		VCDS_NONSTD = 2'h1,
		VCDS_STD    = 2'h2
	} vcds_mode_t;

	typedef struct packed {
		logic hdrive;
		logic ramp_gate;
		logic vblank;
		logic mono_trig;
		logic std_mode;
	} vcds_out_t;
endpackage

// ===== core/vcds_top.sv
`timescale 1ns/100ps
`include "vcds_params.svh"
module vcds_top #(
	parameter int FREE_PERIOD = `VCDS_FREE_PERIOD,
	parameter int IMMUNE_CNT  = `VCDS_IMMUNE_CNT
) (
	input  wire logic               core_clk_i,
	input  wire logic               arst_n_i,
	input  wire logic               integrated_vertical_sync_i,
	input  wire logic               eq_pulse_i,
	input  wire logic               force_nonstd_i,
	input  wire logic               mono_active_i,
	output vcds_pkg::vcds_out_t     vout_o,
	output logic                    line_rate_tick_o,
	output logic                    twice_line_rate_tick_o
);
	localparam logic [9:0] PRE  = `VCDS_VCNT_PRESET;
	// last held count; the step onto 545 loads the preset instead
	localparam logic [9:0] SLAST = 10'(`VCDS_VCNT_STD_END - 1);
	localparam int HPC = `VCDS_CLK_DIV;
	localparam logic [9:0] FEND = 10'(`VCDS_VCNT_PRESET + FREE_PERIOD - 1);
	localparam logic [9:0] IMM  = 10'(`VCDS_VCNT_PRESET + IMMUNE_CNT);
	localparam logic [9:0] BEND = 10'(`VCDS_VCNT_PRESET
		+ `VCDS_BLANK_CLKS / HPC);
	localparam logic [9:0] REND = 10'(`VCDS_VCNT_PRESET
		+ `VCDS_RAMP_CLKS / HPC);
	localparam logic [9:0] EQST = 10'(`VCDS_VCNT_STD_END
		- 2 * `VCDS_EQ_LINES);
	localparam logic [9:0] NEND = 10'(BEND + IMMUNE_CNT);

	function automatic logic in_win(input logic [9:0] v,
		input logic [9:0] lo, input logic [9:0] hi);
		in_win = (v >= lo) && (v <= hi);
	endfunction

	// clock divider and horizontal drive
	logic [3:0] div_q, div_d;
	logic       hdrv_q, hdrv_d;
	logic       tick;
	always_comb begin
		tick   = (div_q == 4'(HPC - 1));
		div_d  = div_q + 4'h1;
		hdrv_d = tick ? ~hdrv_q : hdrv_q;
	end
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_q  <= 4'h0;
			hdrv_q <= 1'b0;
		end else begin
			div_q  <= div_d;
			hdrv_q <= hdrv_d;
		end
	end

	// input edge capture
	logic sync_prev_q, eq_prev_q, sync_pend_q;
	logic sync_prev_d, eq_prev_d, sync_pend_d;
	logic sync_edge, eq_edge;
	always_comb begin
		sync_edge   = integrated_vertical_sync_i & ~sync_prev_q;
		eq_edge     = eq_pulse_i & ~eq_prev_q;
		sync_prev_d = integrated_vertical_sync_i;
		eq_prev_d   = eq_pulse_i;
		// edge wins over the consume at the tick
		sync_pend_d = sync_edge | (sync_pend_q & ~tick);
	end
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync_prev_q <= 1'b0;
			eq_prev_q   <= 1'b0;
			sync_pend_q <= 1'b0;
		end else begin
			sync_prev_q <= sync_prev_d;
			eq_prev_q   <= eq_prev_d;
			sync_pend_q <= sync_pend_d;
		end
	end

	// vertical chain and mode recognition
	vcds_pkg::vcds_mode_t mode_q, mode_d;
	logic [9:0] vcnt_q, vcnt_d;
	logic [2:0] coin_q, coin_d, miss_q, miss_d, noise_q, noise_d;
	logic [3:0] eq_q, eq_d;
	logic       fast_q, fast_d, trig_q, trig_d;
	logic       coincident, restart, fend, eq_ok;
	always_comb begin
		mode_d  = mode_q;
		vcnt_d  = vcnt_q;
		coin_d  = coin_q;
		miss_d  = miss_q;
		noise_d = noise_q;
		eq_d    = eq_q;
		fast_d  = fast_q;
		trig_d  = 1'b0;
		coincident = tick && sync_pend_q && (vcnt_q == SLAST);
		eq_ok   = (eq_q >= 4'(`VCDS_EQ_MIN));
		restart = tick && (mode_q == vcds_pkg::VCDS_NONSTD)
			&& sync_pend_q && (vcnt_q >= IMM);
		fend    = tick && (((mode_q == vcds_pkg::VCDS_STD)
			&& (vcnt_q == SLAST)) || restart
			|| ((mode_q == vcds_pkg::VCDS_NONSTD)
			&& (vcnt_q == FEND)));
		if (sync_edge && in_win(vcnt_q, BEND, NEND)
			&& noise_q != 3'h7)
			noise_d = noise_q + 3'h1;
		if (eq_edge && in_win(vcnt_q, EQST, SLAST) && eq_q != 4'hF)
			eq_d = eq_q + 4'h1;
		if (tick)
			vcnt_d = vcnt_q + 10'h001;
		if (fend) begin
			vcnt_d  = PRE;
			trig_d  = 1'b1;
			noise_d = 3'h0;
			eq_d    = 4'h0;
			fast_d  = (noise_q >= 3'(`VCDS_NOISE_MIN));
			case (mode_q)
			vcds_pkg::VCDS_STD: begin
				if (coincident)
					miss_d = 3'h0;
				else
					miss_d = miss_q + 3'h1;
				if (!coincident
					&& miss_q == 3'(`VCDS_FIELDS_CONF - 1)) begin
					mode_d = vcds_pkg::VCDS_NONSTD;
					miss_d = 3'h0;
					coin_d = 3'h0;
				end
			end
			vcds_pkg::VCDS_NONSTD: begin
				if (coincident) begin
					coin_d = (coin_q == 3'h7) ? 3'h7 : coin_q + 3'h1;
					if (!force_nonstd_i && eq_ok && (fast_q
						|| coin_q >= 3'(`VCDS_FIELDS_CONF - 1))) begin
						mode_d = vcds_pkg::VCDS_STD;
						miss_d = 3'h0;
					end
				end else begin
					coin_d = 3'h0;
				end
			end
			default: mode_d = vcds_pkg::VCDS_NONSTD;
			endcase
		end
		if (force_nonstd_i) begin
			mode_d = vcds_pkg::VCDS_NONSTD;
			if (mode_q == vcds_pkg::VCDS_STD)
				coin_d = 3'h0;
		end
	end
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mode_q  <= vcds_pkg::VCDS_NONSTD;
			vcnt_q  <= PRE;
			coin_q  <= 3'h0;
			miss_q  <= 3'h0;
			noise_q <= 3'h0;
			eq_q    <= 4'h0;
			fast_q  <= 1'b0;
			trig_q  <= 1'b0;
		end else begin
			mode_q  <= mode_d;
			vcnt_q  <= vcnt_d;
			coin_q  <= coin_d;
			miss_q  <= miss_d;
			noise_q <= noise_d;
			eq_q    <= eq_d;
			fast_q  <= fast_d;
			trig_q  <= trig_d;
		end
	end

	// outputs
	logic std;
	logic tick_q, ltick_q;
	always_comb std = (mode_q == vcds_pkg::VCDS_STD);
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tick_q  <= 1'b0;
			ltick_q <= 1'b0;
		end else begin
			tick_q  <= tick;
			ltick_q <= tick & hdrv_q;
		end
	end
	always_comb begin
		vout_o.hdrive    = hdrv_q;
		vout_o.ramp_gate = (vcnt_q < REND);
		vout_o.vblank    = std ? (vcnt_q < BEND) : mono_active_i;
		vout_o.mono_trig = trig_q;
		vout_o.std_mode  = std;
		twice_line_rate_tick_o = tick_q;
		line_rate_tick_o       = ltick_q;
	end

	// checks
	logic [9:0] blk_q;
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			blk_q <= 10'h000;
		else if (vout_o.vblank && std)
			blk_q <= blk_q + 10'h001;
		else
			blk_q <= 10'h000;
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);

	a_div_period: assert property (tick |-> ##16 tick)
		else $error("twice line tick not every 16 clocks");
	a_hdrive_toggle: assert property (tick |=> hdrv_q != $past(hdrv_q))
		else $error("horizontal drive did not toggle");
	a_std_wrap: assert property (std && tick && vcnt_q == SLAST
		|=> vcnt_q == PRE)
		else $error("standard count did not wrap at 545");
	a_free_wrap: assert property (!std && tick && vcnt_q == FEND
		|=> vcnt_q == PRE)
		else $error("free run period wrong");
	a_force_nonstd: assert property (force_nonstd_i |=> !std)
		else $error("forcing input did not leave standard mode");
	a_miss_exit: assert property (std && fend && !coincident
		&& miss_q == 3'h6 |=> !std)
		else $error("standard mode kept after seven bad fields");
	a_std_entry: assert property (!std && coincident && eq_ok
		&& !force_nonstd_i && coin_q == 3'h6 |=> std)
		else $error("standard mode not entered");
	a_entry_needs_eq: assert property ($rose(std) |-> $past(eq_ok))
		else $error("standard mode entered without equalizing pulses");
	a_immunity: assert property (!std && tick && sync_pend_q
		&& vcnt_q < IMM && vcnt_q != FEND |=> vcnt_q != PRE)
		else $error("sync accepted inside immunity window");
	a_blank_width: assert property (std && $fell(vout_o.vblank)
		|-> blk_q == 10'(`VCDS_BLANK_CLKS))
		else $error("blanking width not 608 clocks");
	a_blank_max: assert property (vout_o.vblank && std
		|-> blk_q < 10'(`VCDS_BLANK_CLKS))
		else $error("blanking longer than 608 clocks");

	c_enter_std: cover property ($rose(std));
	c_leave_std: cover property ($fell(std));
	c_fast_entry: cover property ($rose(std) && $past(fast_q)
		&& $past(coin_q) < 3'h6);
	c_free_run: cover property (!std && tick && vcnt_q == FEND);
endmodule // vcds_top

// ===== bench/vcds_field_src.sv
`timescale 1ns/100ps
module vcds_field_src (
	input  wire logic core_clk_i,
	input  wire logic run_i,
	output logic      sync_o,
	output logic      eq_o
);
	int t_q;

	// one standard field of 525 half-lines of 16 clocks
	always @(negedge core_clk_i) begin
		if (!run_i || t_q == 8399) begin
			t_q <= 0;
		end else begin
			t_q <= t_q + 1;
		end
	end

	assign sync_o = run_i && t_q < 48;
	// nine equalizing pulses, one each half-line, just before sync
	assign eq_o = run_i && t_q >= 8256 && t_q <= 8384 && t_q % 16 == 0;
endmodule // vcds_field_src

// ===== bench/vcds_top_tb.sv
`timescale 1ns/100ps
module vcds_top_tb;
	localparam int FREE = 560;
	logic                core_clk     = 1'b0;
	logic                arst_n       = 1'b0;
	logic                force_nonstd = 1'b0;
	logic                mono_active  = 1'b0;
	logic                run          = 1'b0;
	logic                iv_sync;
	logic                eq_pulse;
	logic                line_tick;
	logic                twice_tick;
	vcds_pkg::vcds_out_t vout;
	int                  failures = 0;
	int                  checks   = 0;
	int                  cycles   = 0;
	int                  w;
	int                  p;

	always #20 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 99000) begin
			failures++;
			final_report();
		end
	end

	vcds_top #(.FREE_PERIOD(FREE), .IMMUNE_CNT(20)) u_dut (
		.core_clk_i(core_clk),
		.arst_n_i(arst_n),
		.integrated_vertical_sync_i(iv_sync),
		.eq_pulse_i(eq_pulse),
		.force_nonstd_i(force_nonstd),
		.mono_active_i(mono_active),
		.vout_o(vout),
		.line_rate_tick_o(line_tick),
		.twice_line_rate_tick_o(twice_tick)
	);

	vcds_field_src u_src (
		.core_clk_i(core_clk),
		.run_i(run),
		.sync_o(iv_sync),
		.eq_o(eq_pulse)
	);

	task automatic step();
		@(posedge core_clk);
		#1;
	endtask

	function automatic logic sig(int s);
		case (s)
			0: return twice_tick;
			1: return line_tick;
			2: return vout.ramp_gate;
			4: return vout.hdrive;
			default: return vout.vblank;
		endcase
	endfunction

	// high width and period from one rising edge to the next
	// rise: already in the first high cycle, skip the search
	task automatic meas(input int s, input bit rise = 1'b0);
		w = 0;
		if (!rise) begin
			while (sig(s) === 1'b1) step();
			while (sig(s) !== 1'b1) step();
		end
		while (sig(s) === 1'b1) begin
			step();
			w++;
		end
		p = w;
		while (sig(s) !== 1'b1) begin
			step();
			p++;
		end
	endtask

	task automatic check_num(int got, int exp);
		checks++;
		if (got != exp) begin
			failures++;
			$display("CHECK FAILED %0t count %0d want %0d", $time, got, exp);
		end
	endtask

	task automatic check_bit(logic got, logic exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t level %b want %b", $time, got, exp);
		end
	endtask

	task automatic t_reset();
		check_bit(vout.std_mode, 1'b0);
		check_bit(vout.ramp_gate, 1'b1);
		@(negedge core_clk);
		arst_n = 1'b1;
		meas(0);
		check_num(p, 16);
		meas(1);
		check_num(p, 32);
		meas(4);
		check_num(w, 16);
		check_num(p, 32);
	endtask

	task automatic t_free();
		meas(2);
		check_num(w, 192);
		check_num(p, FREE * 16);
		check_bit(vout.std_mode, 1'b0);
		@(negedge core_clk);
		mono_active = 1'b1;
		#1;
		check_bit(vout.vblank, 1'b1);
		@(negedge core_clk);
		mono_active = 1'b0;
		#1;
		check_bit(vout.vblank, 1'b0);
	endtask

	task automatic t_lock();
		int fields;
		fields = 0;
		@(negedge core_clk);
		run = 1'b1;
		while (vout.std_mode !== 1'b1 && fields < 12) begin
			step();
			if (vout.mono_trig === 1'b1) fields++;
		end
		check_bit(fields >= 7 && fields <= 10, 1'b1);
		check_bit(vout.mono_trig, 1'b1);
		meas(3, 1'b1);
		check_num(w, 608);
		check_num(p, 8400);
	endtask

	task automatic t_force();
		@(negedge core_clk);
		force_nonstd = 1'b1;
		step();
		check_bit(vout.std_mode, 1'b0);
		check_bit(vout.vblank, 1'b0);
	endtask

	task automatic final_report();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge core_clk);
		#1;
		t_reset();
		t_free();
		t_lock();
		t_force();
		final_report();
	end
endmodule // vcds_top_tb
